/* File: core/spi_pins_control_status.sv */
// Chosen here: the APB slave port and the address map.
`timescale 1ns/1ns
// Function
// - A byte is exchanged in exactly eight serial clock cycles, out and in.
// - Master drives the serial clock pin; slave takes it as input.
// - While enabled the block owns data-out and clock pin directions.
// - Slave always uses select as an input, never general I/O.
// - Select high: slave output floats, clock edges ignored, transfer dropped.
// - Master ignores select unless fault detection on, then input-only.
// - Receive enable gates receive-full requests; reset clears it.
// - DMA select reads zero and does nothing.
// - Master select: 1 master, 0 slave; reset selects master.
// - Polarity sets clock idle level; reset clears it.
// - Phase sets sampling relation; reset sets it.
// - Wired-OR mode makes clock and data pins open-drain, pull-ups off.
// - Enable turns block on; clearing it partially resets; reset clears.
// - Transmit enable gates transmit-empty requests; reset clears it.
// - Receive-full sets on byte arrival; status read then data read clears.
// - Error enable lets fault and overflow request interrupts.
// - Overflow: extra byte while full is dropped, held byte kept.
// - Overflow clears by status read then data read, or reset.
// - Fault sets on slave select rise mid-byte or master select low.
// - Fault clears by status read then control write, or reset.
// - Disabled: transmit-empty set, transfer aborted, shifter cleared.
// - Only a data register write clears transmit-empty.
// - Master rate codes select half-period divisor 2, 8, 32 or 128.
// - Master-in pin drives only as selected slave.
module spi_pins_control_status
   import spi_pkg::*;
#(
   parameter int ADDR_W = 12
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [APB_DW-1:0] pwdata,
   output logic [APB_DW-1:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic serial_clock_pin_i,
   output logic serial_clock_pin_o,
   output logic serial_clock_pin_oe,
   input wire logic mosi_i,
   output logic mosi_o,
   output logic mosi_oe,
   input wire logic miso_i,
   output logic miso_o,
   output logic miso_oe,
   input wire logic slave_select_n_i,
   output logic pins_owned,
   output logic select_owned,
   output logic pullup_en,
   output logic irq_rx_err,
   output logic irq_tx
);
   generate
      if (ADDR_W < 4) begin : g_bad_addr
         $error("ADDR_W must be at least 4");
      end
   endgenerate

   // Control fields.
   logic rx_full_irq_enable;
   logic master_select;
   logic cpol;
   logic cpha;
   logic wired_or_mode;
   logic module_enable;
   logic tx_empty_irq_enable;
   logic error_irq_enable;
   logic mode_fault_enable;
   logic rate_select_hi;
   logic rate_select_lo;
   // Flags and their two-step clear arming.
   logic rx_full_flag;
   logic overflow_flag;
   logic mode_fault_flag;
   logic tx_pending;
   logic rxf_armed;
   logic ovf_armed;
   logic mode_fault_flag_armed;
   // Data path.
   logic [7:0] tx_data;
   logic [7:0] rx_data;
   logic [7:0] shifter;
   logic [2:0] bit_count;
   logic busy;
   logic in_bit;
   logic data_out;
   logic sclk_q;
   // Synchronisers.
   logic [N_IN-1:0] pins_raw;
   logic [N_IN-1:0] sync1;
   logic [N_IN-1:0] sync2;
   logic sclk_d;
   logic ss_d;

   rate_if rate ();

   rate_divider u_div (
      .pclk(pclk),
      .presetn(presetn),
      .rate(rate.source)
   );

   assign pins_raw = {slave_select_n_i, miso_i, mosi_i, serial_clock_pin_i};

   genvar gi;
   generate
      for (gi = 0; gi < N_IN; gi++) begin : g_sync
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               sync1[gi] <= 1'b1;
               sync2[gi] <= 1'b1;
            end else begin
               sync1[gi] <= pins_raw[gi];
               sync2[gi] <= sync1[gi];
            end
         end
      end
   endgenerate

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sclk_d <= 1'b1;
         ss_d <= 1'b1;
      end else begin
         sclk_d <= sync2[IN_SCLK];
         ss_d <= sync2[IN_SS];
      end
   end

   // Bus decode; the answer comes on the second access-phase cycle.
   logic access;
   logic commit;
   logic wr_ctrl;
   logic wr_stat;
   logic wr_data;
   logic rd_stat;
   logic rd_data;
   logic mapped;
   logic [3:0] ofs;

   assign ofs = paddr[3:0];
   assign mapped = (paddr[ADDR_W-1:4] == '0) &&
      (ofs == OFS_CONTROL || ofs == OFS_STATUS || ofs == OFS_DATA);
   assign access = psel && penable && !pready;
   assign commit = psel && penable && pready && mapped;
   assign wr_ctrl = commit && pwrite && ofs == OFS_CONTROL;
   assign wr_stat = commit && pwrite && ofs == OFS_STATUS;
   assign wr_data = commit && pwrite && ofs == OFS_DATA;
   assign rd_stat = commit && !pwrite && ofs == OFS_STATUS;
   assign rd_data = commit && !pwrite && ofs == OFS_DATA;

   logic [7:0] control_view;
   logic [7:0] status_view;

   always_comb begin
      control_view = 8'h00;
      control_view[C_RXIE] = rx_full_irq_enable;
      control_view[C_DMA_SELECT] = 1'b0;
      control_view[C_MSTR] = master_select;
      control_view[C_CPOL] = cpol;
      control_view[C_CPHA] = cpha;
      control_view[C_WOM] = wired_or_mode;
      control_view[C_EN] = module_enable;
      control_view[C_TXIE] = tx_empty_irq_enable;
      status_view = 8'h00;
      status_view[S_RXF] = rx_full_flag;
      status_view[S_ERROR_IRQ_ENABLE] = error_irq_enable;
      status_view[S_OVF] = overflow_flag;
      status_view[S_MODE_FAULT_FLAG] = mode_fault_flag;
      status_view[S_TXE] = !tx_pending;
      status_view[S_MODE_FAULT_ENABLE] = mode_fault_enable;
      status_view[S_RATE_HI] = rate_select_hi;
      status_view[S_RATE_LO] = rate_select_lo;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h0000_0000;
      end else begin
         pready <= access;
         pslverr <= access && !mapped;
         if (access && !pwrite && mapped) begin
            case (ofs)
               OFS_CONTROL: prdata <= {24'h00_0000, control_view};
               OFS_STATUS: prdata <= {24'h00_0000, status_view};
               OFS_DATA: prdata <= {24'h00_0000, rx_data};
               default: prdata <= 32'h0000_0000;
            endcase
         end else if (access) begin
            prdata <= 32'h0000_0000;
         end
      end
   end

   // Transfer events.
   logic is_master;
   logic is_slave;
   logic ss_low;
   logic lead_ev;
   logic trail_ev;
   logic start;
   logic done;
   logic master_fault;
   logic slave_fault;
   logic sclk_rise;
   logic sclk_fall;
   logic sclk_q_lead_done;
   logic samp_bit;
   logic [1:0] late_valid;
   logic [1:0] late_last;
   logic [7:0] late_shift;

   assign is_master = module_enable && master_select;
   assign sclk_q_lead_done = sclk_q != cpol;
   assign samp_bit = is_master ? sync2[IN_MISO] : sync2[IN_MOSI];
   assign is_slave = module_enable && !master_select;
   assign ss_low = !sync2[IN_SS];
   assign sclk_rise = sync2[IN_SCLK] && !sclk_d;
   assign sclk_fall = !sync2[IN_SCLK] && sclk_d;
   assign rate.rate_sel = {rate_select_hi, rate_select_lo};
   assign rate.run = is_master && busy;

   always_comb begin
      if (is_master) begin
         lead_ev = rate.tick && busy && !sclk_q_lead_done;
         trail_ev = rate.tick && busy && sclk_q_lead_done;
      end else if (is_slave && ss_low) begin
         // Leading edge leaves the idle level that polarity fixes.
         lead_ev = cpol ? sclk_fall : sclk_rise;
         trail_ev = cpol ? sclk_rise : sclk_fall;
      end else begin
         lead_ev = 1'b0;
         trail_ev = 1'b0;
      end
   end

   always_comb begin
      if (is_master) begin
         start = !busy && tx_pending && !wr_data;
      end else if (is_slave && !busy) begin
         // Phase 0 starts on the select fall, phase 1 on the first edge.
         start = cpha ? lead_ev : (ss_low && ss_d);
      end else begin
         start = 1'b0;
      end
   end

   assign done = is_master ? late_valid[1] && late_last[1] :
      trail_ev && busy && bit_count == LAST_BIT;
   assign master_fault = is_master && mode_fault_enable && ss_low;
   assign slave_fault = is_slave && mode_fault_enable && busy &&
      !ss_low && !ss_d;

   // A master's data-in comes back three cycles late through the pin
   // register and synchroniser, so it is sampled two cycles after the edge.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         late_valid <= 2'h0;
         late_last <= 2'h0;
         late_shift <= 8'h00;
      end else if (!is_master) begin
         late_valid <= 2'h0;
         late_last <= 2'h0;
      end else begin
         late_valid <= {late_valid[0], busy && (cpha ? trail_ev : lead_ev)};
         late_last <= {late_last[0], bit_count == LAST_BIT};
         if (late_valid[1]) begin
            late_shift <= {late_shift[6:0], samp_bit};
         end
      end
   end

   // Control register and the enable, which a master fault drops.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rx_full_irq_enable <= CONTROL_RST[C_RXIE];
         master_select <= CONTROL_RST[C_MSTR];
         cpol <= CONTROL_RST[C_CPOL];
         cpha <= CONTROL_RST[C_CPHA];
         wired_or_mode <= CONTROL_RST[C_WOM];
         module_enable <= CONTROL_RST[C_EN];
         tx_empty_irq_enable <= CONTROL_RST[C_TXIE];
      end else begin
         if (wr_ctrl) begin
            rx_full_irq_enable <= pwdata[C_RXIE];
            master_select <= pwdata[C_MSTR];
            cpol <= pwdata[C_CPOL];
            cpha <= pwdata[C_CPHA];
            wired_or_mode <= pwdata[C_WOM];
            module_enable <= pwdata[C_EN];
            tx_empty_irq_enable <= pwdata[C_TXIE];
         end
         // A second master on the bus forces this one off the pins.
         if (master_fault) begin
            module_enable <= 1'b0;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         error_irq_enable <= STATUS_RST[S_ERROR_IRQ_ENABLE];
         mode_fault_enable <= STATUS_RST[S_MODE_FAULT_ENABLE];
         rate_select_hi <= STATUS_RST[S_RATE_HI];
         rate_select_lo <= STATUS_RST[S_RATE_LO];
      end else if (wr_stat) begin
         error_irq_enable <= pwdata[S_ERROR_IRQ_ENABLE];
         mode_fault_enable <= pwdata[S_MODE_FAULT_ENABLE];
         rate_select_hi <= pwdata[S_RATE_HI];
         rate_select_lo <= pwdata[S_RATE_LO];
      end
   end

   // Flags: clears are written first so that a set in the same cycle wins.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rx_full_flag <= 1'b0;
         overflow_flag <= 1'b0;
         mode_fault_flag <= 1'b0;
         rxf_armed <= 1'b0;
         ovf_armed <= 1'b0;
         mode_fault_flag_armed <= 1'b0;
         rx_data <= 8'h00;
      end else begin
         if (rd_stat) begin
            rxf_armed <= rx_full_flag;
            ovf_armed <= overflow_flag;
            mode_fault_flag_armed <= mode_fault_flag;
         end
         if (rd_data) begin
            if (rxf_armed) begin
               rx_full_flag <= 1'b0;
            end
            if (ovf_armed) begin
               overflow_flag <= 1'b0;
            end
            rxf_armed <= 1'b0;
            ovf_armed <= 1'b0;
         end
         if (wr_ctrl) begin
            if (mode_fault_flag_armed) begin
               mode_fault_flag <= 1'b0;
            end
            mode_fault_flag_armed <= 1'b0;
         end
         if (done) begin
            if (rx_full_flag && !(rd_data && rxf_armed)) begin
               overflow_flag <= 1'b1;
            end else begin
               rx_data <= is_master ? {late_shift[6:0], samp_bit} :
                  {shifter[6:0], cpha ? samp_bit : in_bit};
               rx_full_flag <= 1'b1;
            end
         end
         if (master_fault || slave_fault) begin
            mode_fault_flag <= 1'b1;
         end
      end
   end

   // Transmit holding register.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tx_pending <= 1'b0;
         tx_data <= 8'h00;
      end else begin
         if (wr_data) begin
            tx_data <= pwdata[7:0];
         end
         if (!module_enable) begin
            tx_pending <= 1'b0;
         end else if (wr_data) begin
            tx_pending <= 1'b1;
         end else if (start && tx_pending) begin
            tx_pending <= 1'b0;
         end
      end
   end

   // Shift engine shared by both roles.

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         shifter <= 8'h00;
         bit_count <= 3'h0;
         busy <= 1'b0;
         in_bit <= 1'b0;
         data_out <= 1'b0;
      end else if (!module_enable || (is_slave && !ss_low)) begin
         // Disabling or deselecting abandons the byte in flight.
         shifter <= module_enable ? shifter : 8'h00;
         bit_count <= 3'h0;
         busy <= 1'b0;
         data_out <= module_enable ? data_out : 1'b0;
      end else begin
         if (start) begin
            busy <= 1'b1;
            bit_count <= 3'h0;
            if (tx_pending) begin
               shifter <= tx_data;
               data_out <= tx_data[7];
            end else begin
               data_out <= shifter[7];
            end
         end
         if (lead_ev && (busy || start)) begin
            if (cpha) begin
               data_out <= start && tx_pending ? tx_data[7] : shifter[7];
            end else begin
               in_bit <= samp_bit;
            end
         end
         if (trail_ev && busy) begin
            shifter <= {shifter[6:0], cpha ? samp_bit : in_bit};
            if (!cpha) begin
               data_out <= shifter[6];
            end
            bit_count <= bit_count + 3'h1;
            if (bit_count == LAST_BIT) begin
               busy <= 1'b0;
            end
         end
      end
   end

   // Master serial clock: toggles once per divided half period.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sclk_q <= 1'b0;
      end else if (!is_master || !busy) begin
         sclk_q <= cpol;
      end else if (rate.tick) begin
         sclk_q <= !sclk_q;
      end
   end

   // Pin drive, registered; wired-OR only ever pulls low.
   logic drv_sclk;
   logic drv_mosi;
   logic drv_miso;
   assign drv_sclk = is_master;
   assign drv_mosi = is_master;
   assign drv_miso = is_slave && ss_low;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         serial_clock_pin_o <= 1'b0;
         serial_clock_pin_oe <= 1'b0;
         mosi_o <= 1'b0;
         mosi_oe <= 1'b0;
         miso_o <= 1'b0;
         miso_oe <= 1'b0;
         pins_owned <= 1'b0;
         select_owned <= 1'b0;
         pullup_en <= 1'b1;
         irq_rx_err <= 1'b0;
         irq_tx <= 1'b0;
      end else begin
         serial_clock_pin_o <= wired_or_mode ? 1'b0 : sclk_q;
         serial_clock_pin_oe <= drv_sclk && (!wired_or_mode || !sclk_q);
         mosi_o <= wired_or_mode ? 1'b0 : data_out;
         mosi_oe <= drv_mosi && (!wired_or_mode || !data_out);
         miso_o <= wired_or_mode ? 1'b0 : data_out;
         miso_oe <= drv_miso && (!wired_or_mode || !data_out);
         pins_owned <= module_enable;
         select_owned <= is_slave ||
            (is_master && mode_fault_enable);
         pullup_en <= !wired_or_mode;
         irq_rx_err <= (rx_full_irq_enable && rx_full_flag) ||
            (error_irq_enable && (overflow_flag || mode_fault_flag));
         irq_tx <= tx_empty_irq_enable && !tx_pending &&
            module_enable;
      end
   end
endmodule

/* File: core/spi_pkg.sv */
package spi_pkg;
   localparam int APB_DW = 32;
   // Register byte offsets.
   localparam logic [3:0] OFS_CONTROL = 4'h0;
   localparam logic [3:0] OFS_STATUS = 4'h4;
   localparam logic [3:0] OFS_DATA = 4'h8;
   // Control register bit positions.
   localparam int C_RXIE = 7;
   localparam int C_DMA_SELECT = 6;
   localparam int C_MSTR = 5;
   localparam int C_CPOL = 4;
   localparam int C_CPHA = 3;
   localparam int C_WOM = 2;
   localparam int C_EN = 1;
   localparam int C_TXIE = 0;
   // Status and control register bit positions.
   localparam int S_RXF = 7;
   localparam int S_ERROR_IRQ_ENABLE = 6;
   localparam int S_OVF = 5;
   localparam int S_MODE_FAULT_FLAG = 4;
   localparam int S_TXE = 3;
   localparam int S_MODE_FAULT_ENABLE = 2;
   localparam int S_RATE_HI = 1;
   localparam int S_RATE_LO = 0;
   // Reset values: master and clock phase set, transmit empty set.
   localparam logic [7:0] CONTROL_RST = 8'h28;
   localparam logic [7:0] STATUS_RST = 8'h08;
   // Half-period divisors of the serial clock for rate codes 0 to 3.
   localparam logic [7:0] DIV_0 = 8'h02;
   localparam logic [7:0] DIV_1 = 8'h08;
   localparam logic [7:0] DIV_2 = 8'h20;
   localparam logic [7:0] DIV_3 = 8'h80;
   localparam logic [2:0] LAST_BIT = 3'h7;
   // Synchronised input indices.
   localparam int IN_SCLK = 0;
   localparam int IN_MOSI = 1;
   localparam int IN_MISO = 2;
   localparam int IN_SS = 3;
   localparam int N_IN = 4;
endpackage

/* File: core/rate_if.sv */
`timescale 1ns/1ns
interface rate_if;
   logic [1:0] rate_sel;
   logic run;
   logic tick;
   modport source (input rate_sel, input run, output tick);
   modport sink (output rate_sel, output run, input tick);
endinterface

/* File: core/rate_divider.sv */
`timescale 1ns/1ns
module rate_divider
   import spi_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   rate_if.source rate
);
   logic [7:0] count;
   logic [7:0] divisor;

   always_comb begin
      case (rate.rate_sel)
         2'h0: divisor = DIV_0;
         2'h1: divisor = DIV_1;
         2'h2: divisor = DIV_2;
         default: divisor = DIV_3;
      endcase
   end

   // The count restarts whenever the engine is idle, so the first
   // half period of a byte is always a full one.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         count <= 8'h00;
         rate.tick <= 1'b0;
      end else if (!rate.run) begin
         count <= 8'h00;
         rate.tick <= 1'b0;
      end else if (count == divisor - 8'h01) begin
         count <= 8'h00;
         rate.tick <= 1'b1;
      end else begin
         count <= count + 8'h01;
         rate.tick <= 1'b0;
      end
   end
endmodule

/* File: verif/spi_pins_control_status_properties.sv */
`timescale 1ns/1ns
module spi_checks (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic serial_clock_pin_o,
   input wire logic serial_clock_pin_oe,
   input wire logic mosi_oe,
   input wire logic miso_oe,
   input wire logic slave_select_n_i,
   input wire logic pins_owned,
   input wire logic select_owned,
   input wire logic pullup_en,
   input wire logic irq_rx_err,
   input wire logic irq_tx
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   chk_err_ready: assert property (pslverr |-> pready)
      else $error("Slave error seen without ready.");
   chk_ready_pulse: assert property (pready |=> !pready)
      else $error("Ready stood longer than one cycle.");
   // Two cycles allow for the outputs lagging the enable by one register.
   chk_off_pins: assert property (
      !pins_owned [*2] |-> !serial_clock_pin_oe && !mosi_oe && !miso_oe)
      else $error("Pin driven while disabled.");
   chk_off_select: assert property (
      !pins_owned [*2] |-> !select_owned)
      else $error("Select pin held while disabled.");
   chk_float_miso: assert property (
      slave_select_n_i [*6] |-> !miso_oe)
      else $error("Data-in driven while deselected.");
   chk_slave_clock: assert property (
      miso_oe |-> !serial_clock_pin_oe && !mosi_oe)
      else $error("Slave drives clock or data-out.");
   chk_wired_low: assert property (
      serial_clock_pin_oe && !pullup_en |-> !serial_clock_pin_o)
      else $error("Open-drain clock driven high.");
   chk_tx_enabled: assert property (
      irq_tx |-> pins_owned || $past(pins_owned))
      else $error("Transmit request while disabled.");
   chk_clock_rate: assert property (
      $changed(serial_clock_pin_o) && serial_clock_pin_oe
      |=> $stable(serial_clock_pin_o))
      else $error("Serial clock half period below two cycles.");
   chk_master_fault: assert property (
      select_owned && serial_clock_pin_oe && !slave_select_n_i
      ##1 !slave_select_n_i [*7] |=> !pins_owned)
      else $error("Master kept enable after select fault.");
   cover property (pslverr);
   cover property ($rose(miso_oe));
   cover property ($rose(irq_rx_err));
endmodule

/* File: verif/spi_peer.sv */
`timescale 1ns/1ns
module spi_peer (
   input wire logic sclk,
   input wire logic mosi,
   input wire logic miso,
   output logic miso_o,
   output logic sclk_o,
   output logic mosi_o,
   output logic drive,
   output logic ss_n,
   output logic [7:0] rx_byte
);
   logic [7:0] sh;
   initial begin
      sh = 8'h00;
      miso_o = 1'b0;
      sclk_o = 1'b0;
      mosi_o = 1'b0;
      drive = 1'b0;
      ss_n = 1'b1;
      rx_byte = 8'h00;
   end
   // Slave role: present on the leading edge, sample on the trailing one.
   always @(posedge sclk) if (!drive) miso_o = sh[7];
   always @(negedge sclk) if (!drive) begin
      sh = {sh[6:0], mosi};
      rx_byte = sh;
   end
   // Master role samples late in the low half, after the slave's
   // synchroniser delay has moved the line to the new bit.
   task automatic master_byte(input logic [7:0] b);
      drive = 1'b1;
      ss_n = 1'b0;
      #203;
      for (int i = 7; i >= 0; i--) begin
         sclk_o = 1'b1;
         mosi_o = b[i];
         #32 sclk_o = 1'b0;
         #31 rx_byte = {rx_byte[6:0], miso};
         #1;
      end
      #200 ss_n = 1'b1;
      drive = 1'b0;
   endtask
   task automatic load(input logic [7:0] b);
      sh = b;
   endtask
   task automatic select(input logic v);
      ss_n = v;
   endtask
endmodule

/* File: verif/tb_top.sv */
`timescale 1ns/1ns
module tb_top;
   import spi_pkg::*;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata;
   logic sck_o, sck_oe, mosi_o, mosi_oe, miso_o, miso_oe, ss_n;
   logic pins_owned, select_owned, pullup_en, irq_rx_err, irq_tx;
   logic p_miso, p_sck, p_mosi, drive;
   logic [7:0] p_rx, pb, db;
   wire logic sck_w, mosi_w, miso_w;
   logic [32:0] exp_q[$];
   int errors, cmp_count, cyc;
   int div[4] = '{2, 8, 32, 128};
   // All three lines carry pull-ups, so a released line reads high.
   assign sck_w = sck_oe ? sck_o : drive ? p_sck : 1'b1;
   assign mosi_w = mosi_oe ? mosi_o : drive ? p_mosi : 1'b1;
   assign miso_w = miso_oe ? miso_o : !drive ? p_miso : 1'b1;
   spi_pins_control_status #(.ADDR_W(12)) i_dut (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .serial_clock_pin_i(sck_w),
      .serial_clock_pin_o(sck_o), .serial_clock_pin_oe(sck_oe),
      .mosi_i(mosi_w), .mosi_o(mosi_o), .mosi_oe(mosi_oe),
      .miso_i(miso_w), .miso_o(miso_o), .miso_oe(miso_oe),
      .slave_select_n_i(ss_n), .pins_owned(pins_owned),
      .select_owned(select_owned), .pullup_en(pullup_en),
      .irq_rx_err(irq_rx_err), .irq_tx(irq_tx));
   spi_peer i_peer (.sclk(sck_w), .mosi(mosi_w), .miso(miso_w),
      .miso_o(p_miso), .sclk_o(p_sck), .mosi_o(p_mosi), .drive(drive),
      .ss_n(ss_n), .rx_byte(p_rx));
   initial begin
      pclk = 1'b0;
      forever #4 pclk = ~pclk;
   end
   always @(posedge pclk) cyc <= cyc + 1;
   task automatic close_out();
      $display("Comparisons %0d, errors %0d", cmp_count, errors);
      if (errors == 0 && cmp_count > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic cmp(input string n, input logic [32:0] e,
      input logic [32:0] s);
      cmp_count++;
      if (s !== e) begin
         errors++;
         $display("Error %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic pin(input string n, input logic e, input logic s);
      cmp(n, {32'h0, e}, {32'h0, s});
   endtask
   always @(posedge pclk)
      if (psel && penable && pready === 1'b1 && !pwrite)
         if (exp_q.size() > 0) cmp("read", exp_q.pop_front(),
            {pslverr, prdata});
   task automatic apb(input logic w, input logic [3:0] a,
      input logic [7:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= {8'h00, a};
      pwdata <= {24'h000000, d};
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      apb(1'b1, a, d);
   endtask
   task automatic rd(input logic [3:0] a, input logic [7:0] e);
      exp_q.push_back({25'h0, e});
      apb(1'b0, a, 8'h00);
   endtask
   task automatic settle();
      repeat (8) @(negedge pclk);
   endtask
   task automatic shift(input logic [1:0] r, input logic [7:0] p,
      input logic [7:0] d);
      logic s;
      int t0, n;
      i_peer.load(p);
      wr(OFS_DATA, d);
      s = sck_o;
      for (int k = 0; k < 16; k++) begin
         n = 0;
         while (sck_o === s && n < 1000) begin
            @(posedge pclk);
            n++;
         end
         s = sck_o;
         if (k == 0) t0 = cyc;
      end
      cmp("clock span", 33'(15 * div[r]), 33'(cyc - t0));
      settle();
      cmp("peer byte", {25'h0, d}, {25'h0, p_rx});
   endtask
   initial begin
      void'($urandom(32'h535e));
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0;
      cyc = 0;
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      rd(OFS_CONTROL, 8'h28);
      rd(OFS_STATUS, 8'h08);
      exp_q.push_back({1'b1, 32'h0});
      apb(1'b0, 4'hC, 8'h00);
      wr(OFS_CONTROL, 8'hE8);
      rd(OFS_CONTROL, 8'hA8);
      wr(OFS_CONTROL, 8'hAA);
      settle();
      pin("clock drive", 1'b1, sck_oe);
      pin("data-out drive", 1'b1, mosi_oe);
      pin("select owned", 1'b0, select_owned);
      for (int r = 0; r < 4; r++) begin
         wr(OFS_STATUS, {6'h10, r[1:0]});
         pb = 8'($urandom);
         db = 8'($urandom);
         shift(r[1:0], pb, db);
         pin("receive request", 1'b1, irq_rx_err);
         rd(OFS_STATUS, {6'h32, r[1:0]});
         rd(OFS_DATA, pb);
         rd(OFS_STATUS, {6'h12, r[1:0]});
      end
      wr(OFS_STATUS, 8'h40);
      shift(2'd0, pb, db);
      shift(2'd0, ~pb, ~db);
      pin("error request", 1'b1, irq_rx_err);
      rd(OFS_STATUS, 8'hE8);
      rd(OFS_DATA, pb);
      rd(OFS_STATUS, 8'h48);
      wr(OFS_STATUS, 8'h04);
      wr(OFS_CONTROL, 8'h2A);
      settle();
      pin("fault select owned", 1'b1, select_owned);
      i_peer.select(1'b0);
      settle();
      i_peer.select(1'b1);
      settle();
      pin("fault request off", 1'b0, irq_rx_err);
      rd(OFS_CONTROL, 8'h28);
      rd(OFS_STATUS, 8'h1C);
      wr(OFS_CONTROL, 8'h28);
      rd(OFS_STATUS, 8'h0C);
      wr(OFS_STATUS, 8'h00);
      wr(OFS_CONTROL, 8'h0A);
      db = 8'($urandom);
      pb = 8'($urandom);
      wr(OFS_DATA, db);
      settle();
      pin("slave clock drive", 1'b0, sck_oe);
      pin("slave select owned", 1'b1, select_owned);
      pin("released data-in", 1'b0, miso_oe);
      i_peer.master_byte(pb);
      settle();
      rd(OFS_STATUS, 8'h88);
      rd(OFS_DATA, pb);
      cmp("slave byte", {25'h0, db}, {25'h0, p_rx});
      wr(OFS_CONTROL, 8'h2B);
      settle();
      pin("tx request", 1'b1, irq_tx);
      wr(OFS_CONTROL, 8'h2F);
      settle();
      pin("pull-ups", 1'b0, pullup_en);
      wr(OFS_CONTROL, 8'h29);
      settle();
      pin("owned", 1'b0, pins_owned);
      pin("tx request off", 1'b0, irq_tx);
      rd(OFS_STATUS, 8'h08);
      settle();
      close_out();
   end
   initial begin
      #400000;
      errors++;
      close_out();
   end
endmodule
bind spi_pins_control_status spi_checks i_checks (
   .pclk(pclk), .presetn(presetn), .pready(pready), .pslverr(pslverr),
   .serial_clock_pin_o(serial_clock_pin_o),
   .serial_clock_pin_oe(serial_clock_pin_oe), .mosi_oe(mosi_oe),
   .miso_oe(miso_oe), .slave_select_n_i(slave_select_n_i),
   .pins_owned(pins_owned), .select_owned(select_owned),
   .pullup_en(pullup_en), .irq_rx_err(irq_rx_err), .irq_tx(irq_tx));
